// File: design/nfpe_params.svh
// Purpose: register map, field positions, reset values and counts of the flash parity block
// Assumes: included by its bare name from the package and the top module
// Notes: definitions only
`ifndef NFPE_PARAMS_SVH
`define NFPE_PARAMS_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define NFPE_A_CONF 32'h4e00_0000
`define NFPE_A_CONT 32'h4e00_0004
`define NFPE_A_CMD 32'h4e00_0008
`define NFPE_A_ADDR 32'h4e00_000c
`define NFPE_A_DATA 32'h4e00_0010
`define NFPE_A_MEXP0 32'h4e00_0014
`define NFPE_A_MEXP1 32'h4e00_0018
`define NFPE_A_SEXP 32'h4e00_001c
`define NFPE_A_MRES0 32'h4e00_0020
`define NFPE_A_MRES1 32'h4e00_0024
`define NFPE_A_SRES 32'h4e00_0028

// ************************************************************
// field positions
// ************************************************************
`define NFPE_F_SETUP 13:12
`define NFPE_F_ACTIVE 10:8
`define NFPE_F_HOLD 6:4
`define NFPE_F_STRAPS 3:0
`define NFPE_F_RO_STRAPS 3:1
`define NFPE_F_WIDTH 0
`define NFPE_F_CE 1
`define NFPE_F_RESTART 4
`define NFPE_F_MFRZ 5
`define NFPE_F_SFRZ 6

// ************************************************************
// reset values and write masks
// ************************************************************
`define NFPE_CONF_RST 16'h1000
`define NFPE_CONT_RST 16'h0062
`define NFPE_CONF_WMASK 16'h3771
`define NFPE_CONT_WMASK 16'h0062
`define NFPE_LANE_LO_MASK 32'h00ff_00ff

// ************************************************************
// counts
// ************************************************************
`define NFPE_CAP_DELAY 3'd5
`define NFPE_MAIN_IDX_W 11
`define NFPE_SPARE_IDX_W 4
`define NFPE_PAR_W 28
`define NFPE_SPAR_W 14

`endif

// File: design/nfpe_pkg.sv
// Purpose: types shared by the flash parity block
// Assumes: nfpe_params.svh holds the numbers
// Notes: nothing here is imported; users write nfpe_pkg::name
`include "nfpe_params.svh"

package nfpe_pkg;

   // ************************************************************
   // cycle sequencer states and operations
   // ************************************************************
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ACTIVE, ST_HOLD, ST_DONE} nfpe_state_t;
   typedef enum logic [1:0] {OP_CMD, OP_ADDR, OP_WR, OP_RD} nfpe_op_t;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic large_page_device;
      logic page_capacity_sel;
      logic address_phase_count_sel;
      logic io_width_sel;
   } nfpe_strap_t;

   typedef struct packed {
      logic [1:0] latch_setup_cycles;
      logic [2:0] strobe_active_cycles;
      logic [2:0] strobe_hold_cycles;
   } nfpe_timing_t;

   // running parity: 6 column bits then line pairs per index bit
   function automatic logic [`NFPE_PAR_W-1:0] nfpe_parity_acc(
      input logic [`NFPE_PAR_W-1:0] p,
      input logic [7:0] b,
      input logic [`NFPE_MAIN_IDX_W-1:0] idx);
      logic [`NFPE_PAR_W-1:0] n;
      logic odd;
      n = p;
      odd = ^b;
      n[0] = p[0] ^ (^(b & 8'h55));
      n[1] = p[1] ^ (^(b & 8'haa));
      n[2] = p[2] ^ (^(b & 8'h33));
      n[3] = p[3] ^ (^(b & 8'hcc));
      n[4] = p[4] ^ (^(b & 8'h0f));
      n[5] = p[5] ^ (^(b & 8'hf0));
      for (int k = 0; k < `NFPE_MAIN_IDX_W; k++)
      begin
         n[6+2*k] = p[6+2*k] ^ (odd & ~idx[k]);
         n[7+2*k] = p[7+2*k] ^ (odd & idx[k]);
      end
      return n;
   endfunction

endpackage

// File: design/nfpe_top.sv
// Purpose: flash parity generation, expected parity store, strobe timing and strap capture
// Assumes: apb slave on core_clk_i, flash pins driven straight from this block
// Notes: one flash cycle per apb write to the command, address or data register, and per apb read of the data register
//
// Overview of operation
// RULE1: 16-bit bus: expected parity bytes per unit in 7:0/15:8, next in 23:16/31:24.
// RULE2: 8-bit bus: expected parity in bits 7:0 and 23:16, other lanes unused.
// RULE3: expected parity byte placement does not depend on endianness.
// RULE4: unfrozen generators accumulate parity over every software data read or write.
// RULE5: writing one to restart clears parity; software restarts and unfreezes before use.
// RULE6: main freeze bit 5 and spare freeze bit 6 block their generator when one.
// RULE7: a frozen parity result register holds its value through further transfers.
// RULE8: each data transfer updates main parity results with the running code; the code updates them only while main freeze bit 5 is zero.
// RULE9: unfrozen spare generator updates spare parity result on each data transfer.
// RULE10: software freezes main after a page, then runs spare area and freezes spare.
// RULE11: spare expected parity protects spare area; software stores main parity there.
// RULE12: address cycles drive the same byte on data lanes 7:0 and 15:8.
// RULE13: latch setup field 13:12 resets to 01, sets latch phase cycles.
// RULE14: strobe active field 10:8 resets to 000, strobe low for value plus one.
// RULE15: strobe hold field 6:4 resets to 000, hold phase lasts value plus one.
// RULE16: read-only bit 3 captures large page strap at reset and wake-up.
// RULE17: read-only bit 2 captures page strap at reset and wake-up.
// RULE18: read-only bit 1 captures address phase strap at reset and wake-up.
// RULE19: bit 0 loads width strap at reset and wake-up, software may overwrite.
// RULE20: straps are sampled only at reset and wake-up, later pin changes ignored.
// RULE21: restart control is write-only one-shot and clears both generators.
// RULE22: both freeze bits reset to one, no parity until software unfreezes.
// RULE23: main parity per lane is 28 bits: 22 line plus 6 column.
// RULE24: command or address cycle: latch setup, strobe low active, hold, then next.
`timescale 1ns/1ps
`include "nfpe_params.svh"

module nfpe_top #(
   parameter int unsigned MAIN_IDX_W = `NFPE_MAIN_IDX_W,
   parameter int unsigned SPARE_IDX_W = `NFPE_SPARE_IDX_W
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire nfpe_pkg::nfpe_strap_t strap_pins_i,
   input wire logic wake_i,
   input wire logic [15:0] io_i,
   output logic [15:0] io_o,
   output logic io_oe_n_o,
   output logic cle_o,
   output logic ale_o,
   output logic we_n_o,
   output logic re_n_o,
   output logic ce_n_o
);

   // ************************************************************
   // apb decode
   // ************************************************************
   wire logic acc_w = psel_i & penable_i;
   wire logic setup_ph_w = psel_i & ~penable_i;
   wire logic hit_conf = (paddr_i == `NFPE_A_CONF);
   wire logic hit_cont = (paddr_i == `NFPE_A_CONT);
   wire logic hit_cmd = (paddr_i == `NFPE_A_CMD);
   wire logic hit_addr = (paddr_i == `NFPE_A_ADDR);
   wire logic hit_data = (paddr_i == `NFPE_A_DATA);
   wire logic hit_mexp0 = (paddr_i == `NFPE_A_MEXP0);
   wire logic hit_mexp1 = (paddr_i == `NFPE_A_MEXP1);
   wire logic hit_sexp = (paddr_i == `NFPE_A_SEXP);
   wire logic hit_mres0 = (paddr_i == `NFPE_A_MRES0);
   wire logic hit_mres1 = (paddr_i == `NFPE_A_MRES1);
   wire logic hit_sres = (paddr_i == `NFPE_A_SRES);
   wire logic hit_any = hit_conf | hit_cont | hit_cmd | hit_addr | hit_data | hit_mexp0
                        | hit_mexp1 | hit_sexp | hit_mres0 | hit_mres1 | hit_sres;
   wire logic is_flash = (pwrite_i & (hit_cmd | hit_addr | hit_data)) | (~pwrite_i & hit_data);

   nfpe_pkg::nfpe_state_t st_q;
   nfpe_pkg::nfpe_state_t st_d;
   nfpe_pkg::nfpe_op_t op_q;
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic [15:0] io_q;
   logic [15:0] conf_q;
   logic [15:0] cont_q;
   logic [31:0] mexp0_q;
   logic [31:0] mexp1_q;
   logic [31:0] sexp_q;
   logic [31:0] prdata_q;

   assign pready_o = ~is_flash | (st_q == nfpe_pkg::ST_DONE);
   assign pslverr_o = acc_w & ~hit_any;
   assign prdata_o = prdata_q;

   wire logic wr_en = acc_w & pwrite_i & pready_o & hit_any;
   wire logic width16 = conf_q[`NFPE_F_WIDTH];
   wire logic mfrz = cont_q[`NFPE_F_MFRZ];
   wire logic sfrz = cont_q[`NFPE_F_SFRZ];
   wire logic restart_w = wr_en & hit_cont & pwdata_i[`NFPE_F_RESTART]; // [RULE5] [RULE21]

   nfpe_pkg::nfpe_timing_t tim;
   assign tim = {conf_q[`NFPE_F_SETUP], conf_q[`NFPE_F_ACTIVE], conf_q[`NFPE_F_HOLD]};

   // ************************************************************
   // strap capture
   // ************************************************************
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;
   logic [3:0] filt_q;
   logic [2:0] cap_q;
   wire logic cap_w = (cap_q == 3'd1);
   wire logic [2:0] cap_d = wake_i ? `NFPE_CAP_DELAY : ((cap_q != 3'd0) ? cap_q - 3'd1 : 3'd0);
   wire logic [3:0] filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         s3_q <= 4'h0;
         filt_q <= 4'h0;
         cap_q <= `NFPE_CAP_DELAY;
      end
      else
      begin
         s1_q <= strap_pins_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
         cap_q <= cap_d;
      end
   end

   // ************************************************************
   // configuration, control and expected parity registers
   // ************************************************************
   wire logic [15:0] conf_wr = (pwdata_i[15:0] & `NFPE_CONF_WMASK) | (conf_q & ~`NFPE_CONF_WMASK);
   wire logic [15:0] conf_d = cap_w ? {conf_q[15:4], filt_q} // [RULE16] [RULE17] [RULE18] [RULE19] [RULE20]
                              : (wr_en & hit_conf) ? conf_wr : conf_q; // [RULE13] [RULE14] [RULE15]
   wire logic [15:0] cont_d = (wr_en & hit_cont) ? (pwdata_i[15:0] & `NFPE_CONT_WMASK) : cont_q; // [RULE6]

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         conf_q <= `NFPE_CONF_RST;
         cont_q <= `NFPE_CONT_RST; // [RULE22]
         mexp0_q <= 32'h0000_0000;
         mexp1_q <= 32'h0000_0000;
         sexp_q <= 32'h0000_0000;
      end
      else
      begin
         conf_q <= conf_d;
         cont_q <= cont_d;
         mexp0_q <= (wr_en & hit_mexp0) ? pwdata_i : mexp0_q;
         mexp1_q <= (wr_en & hit_mexp1) ? pwdata_i : mexp1_q;
         sexp_q <= (wr_en & hit_sexp) ? pwdata_i : sexp_q;
      end
   end

   // ************************************************************
   // flash cycle sequencer
   // ************************************************************
   wire logic start_w = acc_w & is_flash & (st_q == nfpe_pkg::ST_IDLE);
   nfpe_pkg::nfpe_op_t op_new;
   assign op_new = ~pwrite_i ? nfpe_pkg::OP_RD : hit_cmd ? nfpe_pkg::OP_CMD
                   : hit_addr ? nfpe_pkg::OP_ADDR : nfpe_pkg::OP_WR;
   wire logic latch_op = (op_new == nfpe_pkg::OP_CMD) | (op_new == nfpe_pkg::OP_ADDR);
   wire logic [15:0] io_new = (op_new == nfpe_pkg::OP_ADDR) ? {2{pwdata_i[7:0]}} // [RULE12]
                              : {pwdata_i[15:8] & {8{width16}}, pwdata_i[7:0]};

   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         nfpe_pkg::ST_IDLE:
            if (start_w)
            begin
               if (latch_op && tim.latch_setup_cycles != 2'd0)
               begin
                  st_d = nfpe_pkg::ST_SETUP;
                  cnt_d = {1'b0, tim.latch_setup_cycles} - 3'd1; // [RULE13] [RULE24]
               end
               else
               begin
                  st_d = nfpe_pkg::ST_ACTIVE;
                  cnt_d = tim.strobe_active_cycles;
               end
            end
         nfpe_pkg::ST_SETUP:
            if (cnt_q == 3'd0)
            begin
               st_d = nfpe_pkg::ST_ACTIVE;
               cnt_d = tim.strobe_active_cycles; // [RULE14]
            end
            else
               cnt_d = cnt_q - 3'd1;
         nfpe_pkg::ST_ACTIVE:
            if (cnt_q == 3'd0)
            begin
               st_d = nfpe_pkg::ST_HOLD;
               cnt_d = tim.strobe_hold_cycles; // [RULE15]
            end
            else
               cnt_d = cnt_q - 3'd1;
         nfpe_pkg::ST_HOLD:
            if (cnt_q == 3'd0)
               st_d = nfpe_pkg::ST_DONE; // [RULE24]
            else
               cnt_d = cnt_q - 3'd1;
         nfpe_pkg::ST_DONE:
            st_d = nfpe_pkg::ST_IDLE;
         default:
            st_d = nfpe_pkg::ST_IDLE;
      endcase
   end

   wire logic busy = (st_q == nfpe_pkg::ST_SETUP) | (st_q == nfpe_pkg::ST_ACTIVE)
                     | (st_q == nfpe_pkg::ST_HOLD);
   wire logic strobe_end = (st_q == nfpe_pkg::ST_ACTIVE) & (cnt_q == 3'd0);
   wire logic xfer_w = strobe_end & ((op_q == nfpe_pkg::OP_WR) | (op_q == nfpe_pkg::OP_RD));
   wire logic [15:0] xdata = (op_q == nfpe_pkg::OP_RD) ? io_i : io_q;

   assign cle_o = busy & (op_q == nfpe_pkg::OP_CMD);
   assign ale_o = busy & (op_q == nfpe_pkg::OP_ADDR);
   assign we_n_o = ~((st_q == nfpe_pkg::ST_ACTIVE) & (op_q != nfpe_pkg::OP_RD));
   assign re_n_o = ~((st_q == nfpe_pkg::ST_ACTIVE) & (op_q == nfpe_pkg::OP_RD));
   assign io_oe_n_o = ~(busy & (op_q != nfpe_pkg::OP_RD));
   assign io_o = io_q;
   assign ce_n_o = cont_q[`NFPE_F_CE];

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= nfpe_pkg::ST_IDLE;
         op_q <= nfpe_pkg::OP_CMD;
         cnt_q <= 3'd0;
         io_q <= 16'h0000;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         op_q <= start_w ? op_new : op_q;
         io_q <= start_w ? io_new : io_q;
      end
   end

   // ************************************************************
   // parity generators, one per byte lane
   // ************************************************************
   logic [MAIN_IDX_W-1:0] midx_q;
   logic [SPARE_IDX_W-1:0] sidx_q;
   wire logic mupd = xfer_w & ~mfrz; // [RULE4] [RULE6]
   wire logic supd = xfer_w & ~sfrz; // [RULE9]

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         midx_q <= '0;
         sidx_q <= '0;
      end
      else
      begin
         midx_q <= restart_w ? '0 : mupd ? midx_q + 1'b1 : midx_q;
         sidx_q <= restart_w ? '0 : supd ? sidx_q + 1'b1 : sidx_q;
      end
   end

   for (genvar g = 0; g < 2; g++)
   begin : lane
      logic [`NFPE_PAR_W-1:0] m_q;
      logic [`NFPE_SPAR_W-1:0] s_q;
      wire logic en = (g == 0) | width16;
      wire logic [7:0] b = xdata[8*g +: 8];
      wire logic [`NFPE_PAR_W-1:0] m_acc = nfpe_pkg::nfpe_parity_acc(m_q, b,
                                         `NFPE_MAIN_IDX_W'(midx_q)); // [RULE23]
      wire logic [`NFPE_PAR_W-1:0] s_acc = nfpe_pkg::nfpe_parity_acc(
                                         {{(`NFPE_PAR_W-`NFPE_SPAR_W){1'b0}}, s_q}, b,
                                         `NFPE_MAIN_IDX_W'(sidx_q));
      always_ff @(posedge core_clk_i or negedge rst_n_i)
      begin
         if (!rst_n_i)
         begin
            m_q <= '0;
            s_q <= '0;
         end
         else
         begin
            m_q <= restart_w ? '0 : (mupd & en) ? m_acc : m_q; // [RULE7] [RULE8]
            s_q <= restart_w ? '0 : (supd & en) ? s_acc[`NFPE_SPAR_W-1:0] : s_q; // [RULE7]
         end
      end
   end

   // ************************************************************
   // read data
   // ************************************************************
   wire logic [31:0] lane_mask = width16 ? 32'hffff_ffff : `NFPE_LANE_LO_MASK; // [RULE1] [RULE2]
   wire logic [31:0] sres_w = {2'b00, lane[1].s_q, 2'b00, lane[0].s_q};
   wire logic [31:0] rd_mux = hit_conf ? {16'h0000, conf_q}
                              : hit_cont ? {16'h0000, cont_q}
                              : hit_mexp0 ? (mexp0_q & lane_mask) // [RULE3]
                              : hit_mexp1 ? (mexp1_q & lane_mask)
                              : hit_sexp ? (sexp_q & lane_mask)
                              : hit_mres0 ? {4'h0, lane[0].m_q}
                              : hit_mres1 ? {4'h0, lane[1].m_q}
                              : hit_sres ? sres_w : 32'h0000_0000;

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         prdata_q <= 32'h0000_0000;
      else if (setup_ph_w && !pwrite_i && !hit_data)
         prdata_q <= rd_mux;
      else if (strobe_end && op_q == nfpe_pkg::OP_RD)
         prdata_q <= {16'h0000, (width16 ? io_i : {8'h00, io_i[7:0]})};
      else
         prdata_q <= prdata_q;
   end

   // ************************************************************
   // checks
   // ************************************************************
   logic [2:0] seg_q;
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         seg_q <= 3'd0;
      else
         seg_q <= (st_d != st_q) ? 3'd0 : seg_q + 3'd1;
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_restart;
      restart_w;
   endsequence
   sequence s_exp_rd;
      setup_ph_w && !pwrite_i && (hit_mexp0 || hit_mexp1 || hit_sexp) && !width16;
   endsequence

   AST_RESTART_CLEARS: assert property (s_restart |=> (lane[0].m_q == '0) && (sidx_q == '0)) // [RULE5]
      else $error("parity not cleared by restart");
   AST_MAIN_FROZEN: assert property (mfrz && !restart_w |=> $stable(lane[0].m_q)) // [RULE7]
      else $error("frozen main parity changed");
   AST_SPARE_FROZEN: assert property (sfrz && !restart_w |=> $stable(lane[0].s_q)) // [RULE6]
      else $error("frozen spare parity changed");
   AST_MAIN_UPDATES: assert property (mupd && !restart_w && (^xdata[7:0]) |=> !$stable(lane[0].m_q)) // [RULE8]
      else $error("main parity did not update");
   AST_SETUP_LEN: assert property ((st_q == nfpe_pkg::ST_SETUP && st_d != nfpe_pkg::ST_SETUP) // [RULE13]
      |-> seg_q == ({1'b0, tim.latch_setup_cycles} - 3'd1))
      else $error("latch setup length wrong");
   AST_ACTIVE_LEN: assert property ((st_q == nfpe_pkg::ST_ACTIVE && st_d != nfpe_pkg::ST_ACTIVE) // [RULE14]
      |-> seg_q == tim.strobe_active_cycles && !we_n_o != !re_n_o)
      else $error("strobe active length wrong");
   AST_HOLD_LEN: assert property ((st_q == nfpe_pkg::ST_HOLD && st_d != nfpe_pkg::ST_HOLD) // [RULE15]
      |-> seg_q == tim.strobe_hold_cycles && we_n_o && re_n_o)
      else $error("strobe hold length wrong");
   AST_ADDR_DUP: assert property (ale_o && !we_n_o |-> io_o[15:8] == io_o[7:0]) // [RULE12]
      else $error("address lanes differ");
   AST_EXP_8BIT: assert property (s_exp_rd |=> prdata_q[15:8] == 8'h00 && prdata_q[31:24] == 8'h00) // [RULE2]
      else $error("unused expected parity lanes not zero");
   AST_STRAP_HOLD: assert property (!cap_w |=> $stable(conf_q[`NFPE_F_RO_STRAPS])) // [RULE20]
      else $error("strap bits changed outside capture");

endmodule

// File: bench/nfpe_flash_model.sv
// Purpose: flash device on the far side of the parity block
// Assumes: strobes are active low, one chip on the bus
// Notes: released data lines show the inverse of the last read value;
// reads put the inverse byte on the upper lane, so 8-bit masking is visible
`timescale 1ns/1ps

module nfpe_flash_model (
   input wire logic re_n_i,
   input wire logic we_n_i,
   input wire logic [15:0] bus_i,
   input wire logic [7:0] rd_byte_i,
   output logic [15:0] io_o,
   output logic [15:0] latched_o
);
   logic [15:0] last_q = 16'h0000;

   // ****
   // read drive and write latch
   // ****
   assign io_o = re_n_i ? ~last_q : {~rd_byte_i, rd_byte_i};

   always @(posedge re_n_i)
      last_q = {~rd_byte_i, rd_byte_i};

   always @(posedge we_n_i)
      latched_o = bus_i;
endmodule

// File: bench/nfpe_top_tb_top.sv
// Purpose: self-checking bench of the flash parity block
// Assumes: apb master with one idle cycle between transfers
// Notes: the driver queues expected results, a monitor checks them
`timescale 1ns/1ps
`include "nfpe_params.svh"

module nfpe_top_tb_top;
   typedef struct packed {logic w; logic er; logic [31:0] d;} nfpe_note_t;
   logic clk, rst_n, psel, penable, pwrite, wake, pready, pslverr;
   logic cle, ale, we_n, re_n, ce_n, io_oe_n;
   logic [31:0] paddr, pwdata, prdata, seed, r;
   logic [27:0] ep, es;
   logic [15:0] io_i, io_o, latched;
   logic [7:0] rd_byte, b;
   nfpe_pkg::nfpe_strap_t straps;
   nfpe_note_t q[$];
   nfpe_note_t cnote;
   int n_mismatch, checks_done, cnt_l, cnt_w, l0, w0;

   nfpe_top dut (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .strap_pins_i(straps), .wake_i(wake),
      .io_i(io_i), .io_o(io_o), .io_oe_n_o(io_oe_n), .cle_o(cle), .ale_o(ale),
      .we_n_o(we_n), .re_n_o(re_n), .ce_n_o(ce_n));
   nfpe_flash_model flash (.re_n_i(re_n), .we_n_i(we_n), .bus_i(io_o),
      .rd_byte_i(rd_byte), .io_o(io_i), .latched_o(latched));

   // ****
   // helpers
   // ****
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return v[0] ? (v >> 1) ^ 32'h8020_0003 : v >> 1;
   endfunction

   function automatic logic [27:0] par(input logic [27:0] p, input logic [7:0] v,
      input int i, input int nl);
      logic [47:0] m;
      m = 48'hf00f_cc33_aa55;
      for (int k = 0; k < 6; k++)
         p[k] ^= ^(v & m[8*k+:8]);
      for (int k = 0; k < nl; k++)
      begin
         p[6+2*k] ^= (^v) & ~i[k];
         p[7+2*k] ^= (^v) & i[k];
      end
      return p;
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      if (n_mismatch == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // write data or expected read data in d
   task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d,
      input logic er = 1'b0);
      q.push_back('{w, er, d});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   always @(posedge clk)
      if (psel && penable && pready === 1'b1)
      begin
         cnote = q.pop_front();
         cmp({31'h0, pslverr}, {31'h0, cnote.er});
         if (!cnote.w)
            cmp(prdata, cnote.d);
      end

   always @(posedge clk)
   begin
      if (cle || ale)
         cnt_l++;
      if (!we_n)
         cnt_w++;
      if (!we_n || !re_n)
         cmp({31'h0, io_oe_n}, {31'h0, ~re_n});
   end

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      #200us;
      n_mismatch++;
      conclude();
   end

   // ****
   // scenarios
   // ****
   initial
   begin
      {psel, penable, pwrite, wake, paddr, pwdata, rd_byte} = '0;
      rst_n = 1'b0;
      straps = 4'b0100;
      seed = 32'h5930;
      ep = '0;
      es = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      apb(0, `NFPE_A_CONF, 32'h1004);
      apb(0, `NFPE_A_CONT, 32'h0062);
      straps <= 4'b1011;
      apb(0, `NFPE_A_CONF, 32'h1004);
      for (int t = 0; t < 4; t++)
      begin
         seed = lfsr(seed);
         r = t == 0 ? 32'h3770 : t == 1 ? 32'h0 : {18'h0, seed[1:0], 1'b0, seed[4:2], 1'b0,
            seed[7:5], 4'h0};
         apb(1, `NFPE_A_CONF, r);
         apb(0, `NFPE_A_CONF, r | 32'h4);
         l0 = cnt_l;
         w0 = cnt_w;
         apb(1, `NFPE_A_CMD, {24'h0, seed[15:8]});
         cmp(cnt_l - l0, r[13:12] + r[10:8] + r[6:4] + 2);
         cmp(cnt_w - w0, r[10:8] + 1);
         apb(1, `NFPE_A_ADDR, {24'h0, seed[23:16]});
         cmp({16'h0, latched}, {16'h0, {2{seed[23:16]}}});
      end
      apb(1, `NFPE_A_CONT, 32'h0052);
      apb(0, `NFPE_A_CONT, 32'h0042);
      apb(0, `NFPE_A_MRES0, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         b = seed[7:0];
         rd_byte <= b;
         apb(i[0], `NFPE_A_DATA, {24'h0, b});
         ep = par(ep, b, i, 11);
      end
      apb(0, `NFPE_A_MRES0, {4'h0, ep});
      apb(0, `NFPE_A_MRES1, 32'h0);
      apb(1, `NFPE_A_CONT, 32'h0022);
      for (int i = 0; i < 3; i++)
      begin
         seed = lfsr(seed);
         apb(1, `NFPE_A_DATA, {24'h0, seed[7:0]});
         es = par(es, seed[7:0], i, 4);
      end
      apb(0, `NFPE_A_MRES0, {4'h0, ep});
      apb(0, `NFPE_A_SRES, {18'h0, es[13:0]});
      apb(1, `NFPE_A_CONT, 32'h0062);
      apb(1, `NFPE_A_DATA, 32'h0000_005a);
      apb(0, `NFPE_A_SRES, {18'h0, es[13:0]});
      apb(1, 32'h4e00_0100, 32'hffff_ffff, 1'b1);
      apb(0, 32'h4e00_0100, 32'h0, 1'b1);
      apb(1, `NFPE_A_MEXP0, 32'ha5c3_5a3c);
      apb(0, `NFPE_A_MEXP0, 32'h00c3_003c);
      apb(1, `NFPE_A_CONF, 32'hffff_ffff);
      apb(0, `NFPE_A_CONF, 32'h0000_3775);
      apb(0, `NFPE_A_MEXP0, 32'ha5c3_5a3c);
      apb(1, `NFPE_A_CONT, 32'h0000_0050);
      cmp({31'h0, ce_n}, 32'h0);
      ep = '0;
      es = '0;
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         b = seed[7:0];
         rd_byte <= b;
         r = i[0] ? {16'h0, seed[23:8]} : {16'h0, ~b, b};
         apb(i[0], `NFPE_A_DATA, r);
         ep = par(ep, r[7:0], i, 11);
         es = par(es, r[15:8], i, 11);
      end
      apb(0, `NFPE_A_MRES0, {4'h0, ep});
      apb(0, `NFPE_A_MRES1, {4'h0, es});
      apb(1, `NFPE_A_SEXP, seed);
      apb(0, `NFPE_A_SEXP, seed);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (8) @(posedge clk);
      apb(0, `NFPE_A_CONF, 32'h0000_377b);
      conclude();
   end
endmodule
